// ===== tss_cal_seq.sv
`timescale 1ns/1ps
`default_nettype none

module tss_cal_seq #(
  parameter logic [23:0] WAIT_CYC = 24'(tss_pkg::CAL_WAIT_CYC)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ana_req_i,
  input wire logic dig_req_i,
  output logic ana_start_o,
  output logic dig_start_o,
  output logic busy_o
);

  tss_pkg::tss_cal_state_t s;
  tss_pkg::tss_cal_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.ana_start = 1'b0;
    next_s.dig_start = 1'b0;
    case (s.st)
      tss_pkg::TSS_CAL_IDLE: begin
        // Both in one write: analog now, digital after the settle wait
        if (ana_req_i && dig_req_i) begin // R17
          next_s.ana_start = 1'b1;
          next_s.cnt = '0;
          next_s.st = tss_pkg::TSS_CAL_WAIT;
        end else if (ana_req_i) begin // R15
          next_s.ana_start = 1'b1;
        end else if (dig_req_i) begin // R15
          next_s.dig_start = 1'b1;
        end
      end
      tss_pkg::TSS_CAL_WAIT: begin
        // New requests ignored until the automatic digital start
        if (s.cnt >= WAIT_CYC - 24'h1) begin // R17
          next_s.dig_start = 1'b1;
          next_s.st = tss_pkg::TSS_CAL_IDLE;
        end else begin
          next_s.cnt = s.cnt + 24'h1;
        end
      end
      default: begin
        next_s.st = tss_pkg::TSS_CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s.st <= tss_pkg::TSS_CAL_IDLE;
      s.cnt <= '0;
      s.ana_start <= 1'b0;
      s.dig_start <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign ana_start_o = s.ana_start;
  assign dig_start_o = s.dig_start;
  assign busy_o = (s.st == tss_pkg::TSS_CAL_WAIT);

endmodule

`default_nettype wire

// ===== tss_host_side.sv
`timescale 1ns/1ps
`default_nettype none
module tss_host_side #(
  parameter int HOLD_CYC = 100
) (
  input wire logic clk_i,
  input wire logic release_i,
  input wire logic [7:0] rssi_i,
  output logic hw_reset_n_o,
  output logic [7:0] rssi_code_o
);
  int cnt = 0;
  initial begin
    hw_reset_n_o = 1'b0;
    rssi_code_o = 8'h00;
  end
  // Reference settling scaled down from 10 ms to keep the run short
  always @(posedge clk_i) begin
    if (!release_i) begin
      cnt <= 0;
      hw_reset_n_o <= 1'b0;
    end else if (cnt < HOLD_CYC) begin
      cnt <= cnt + 1;
    end else begin
      hw_reset_n_o <= 1'b1;
    end
    rssi_code_o <= rssi_i;
  end
endmodule
`default_nettype wire

// ===== tss_pkg.sv
package tss_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_FREQ_FIRST = 8'h01;
  localparam logic [7:0] IDX_FREQ_LAST = 8'h08;
  localparam logic [7:0] IDX_CP_HI = 8'h0a;
  localparam logic [7:0] IDX_CP_LO = 8'h0b;
  localparam logic [7:0] IDX_FAST = 8'h0c;
  localparam logic [7:0] IDX_LO_DIVIDE_SELECT = 8'h12;
  localparam logic [7:0] IDX_TXLVL = 8'h13;
  localparam logic [7:0] IDX_CAL = 8'h17;
  localparam logic [7:0] IDX_POWER = 8'h2e;
  localparam logic [7:0] IDX_RSSI = 8'h3a;
  localparam logic [7:0] IDX_STATUS = 8'h3b;
  localparam logic [7:0] IDX_SOFT_RST = 8'h3c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_FAST_LOCK = 0;
  localparam int POS_CP_HI = 0;
  localparam int POS_PWR_REF = 0;
  localparam int POS_PWR_RX = 1;
  localparam int POS_PWR_CLKBUF = 2;
  localparam int POS_PWR_SYNTH = 3;
  localparam int POS_CAL_ANA = 0;
  localparam int POS_CAL_DIG = 1;
  localparam int POS_CAL_ALT_ANA = 2;
  localparam int POS_CAL_ALT_DIG = 3;
  localparam int POS_CAL_BUSY = 4;
  localparam int POS_ST_FREQ_VALID = 0;
  localparam int POS_ST_FAULT = 1;
  localparam int POS_ST_CAL_BUSY = 2;
  localparam int POS_ST_HW_READY = 3;
  localparam int POS_SOFT_RST = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [63:0] RST_FREQ = 64'h0;
  localparam logic [3:0] RST_POWER = 4'h0;
  localparam logic [1:0] RST_FIELD2 = 2'h0;
  localparam logic [31:0] RST_WORD = 32'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CAL_WAIT_NS = 1500000;
  localparam int CAL_WAIT_CYC = CAL_WAIT_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 24;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TSS_CAL_IDLE = 2'b01,
    TSS_CAL_WAIT = 2'b10
  } tss_cal_st_t;

  typedef struct packed {
    tss_cal_st_t st;
    logic [CNT_W-1:0] cnt;
    logic ana_start;
    logic dig_start;
  } tss_cal_state_t;

  typedef struct packed {
    logic ref_on;
    logic rx_analog_on;
    logic clock_buffer_on;
    logic synth_on;
  } tss_power_t;

  typedef struct packed {
    logic [1:0] hw_sync;
    logic soft_reset_cmd;
    logic [7:0][7:0] freq_regs;
    logic [7:0] cp_hi;
    logic [7:0] cp_lo;
    logic fast_lock_enable;
    logic [1:0] lo_divide_select;
    logic [1:0] tx_output_level;
    logic [3:0] power;
    logic synth_prev;
    logic [63:0] freq_active;
    logic freq_valid;
    logic freq_load;
    logic freq_fast;
    logic synth_fault;
    logic ack;
    logic [31:0] dat;
  } tss_state_t;

endpackage

// ===== tss_top.sv
// What this block and its host do
// R1: Host holds reset low until reference settles.
// R2: Register writes ignored while hardware reset low.
// R3: Host enables reference power before receive power.
// R4: Frequency applies only when register 0x08 written.
// R5: Host powers synth, buffer, reference before programming.
// R6: Host waits 500 us before frequency commit; the test recommits at once after synth power-up.
// R7: Fast-lock bit selects fast lock-up on change.
// R8: Host powers synth down together or in order.
// R9: Host programs frequency after synth power enable.
// R10: Oscillator off no earlier than synth disable.
// R11: Synth power-down clears frequency, keeps stored registers.
// R12: Host recommits frequency after synth power-up.
// R13: Host avoids synth disable in forbidden states; the test makes one on purpose to raise the fault.
// R14: Forbidden disable recovered by buffer off or reset.
// R15: Calibration starts on writes to register 0x17.
// R16: Host waits 1.5 ms between separate calibrations.
// R17: Both bits together: analog, then digital automatically.
// R18: Charge-pump current in 32 steps, 80-2560 uA.
// R19: Signal strength readable as 8-bit code.
// R20: Transmit level chosen by 2-bit field.
// R21: Transmit divider ratio chosen by 2-bit field.
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module tss_top #(
  parameter logic [23:0] CAL_WAIT_CYC = 24'(tss_pkg::CAL_WAIT_CYC)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic hw_reset_n_i,
  input wire logic [7:0] rssi_code_i,
  output tss_pkg::tss_power_t power_o,
  output logic [63:0] freq_word_o,
  output logic freq_load_o,
  output logic fast_lock_o,
  output logic synth_fault_o,
  output logic [4:0] cp_current_code_o,
  output logic [1:0] tx_output_level_o,
  output logic [1:0] lo_divide_select_o,
  output logic analog_offset_cal_start_o,
  output logic digital_offset_cal_start_o
);

  tss_pkg::tss_state_t s;
  tss_pkg::tss_state_t next_s;

  logic hw_ready;
  logic clear_all;
  logic wr_en;
  logic rd_take;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic cal_ana_req;
  logic cal_dig_req;
  logic cal_busy;
  logic cal_ana_start;
  logic cal_dig_start;
  logic [7:0] rd_byte;
  logic synth_fall;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign hw_ready = s.hw_sync[1];
  assign clear_all = rst_i || !hw_ready || s.soft_reset_cmd;
  assign idx = wb_adr_i[9:2];
  assign wbyte = wb_dat_i[7:0];
  // Write lands at the acknowledging edge only
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && s.ack
    && wb_sel_i[0] && hw_ready && !s.soft_reset_cmd; // R2
  assign rd_take = wb_cyc_i && wb_stb_i && !s.ack;

  assign cal_ana_req = wr_en && (idx == tss_pkg::IDX_CAL)
    && (wbyte[tss_pkg::POS_CAL_ANA] || wbyte[tss_pkg::POS_CAL_ALT_ANA]);
  assign cal_dig_req = wr_en && (idx == tss_pkg::IDX_CAL)
    && (wbyte[tss_pkg::POS_CAL_DIG] || wbyte[tss_pkg::POS_CAL_ALT_DIG]);

  tss_cal_seq #(
    .WAIT_CYC(CAL_WAIT_CYC)
  ) u_cal (
    .clk_i(clk_i),
    .rst_i(clear_all),
    .ana_req_i(cal_ana_req),
    .dig_req_i(cal_dig_req),
    .ana_start_o(cal_ana_start),
    .dig_start_o(cal_dig_start),
    .busy_o(cal_busy)
  );

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_byte = tss_pkg::RST_BYTE;
    if (idx >= tss_pkg::IDX_FREQ_FIRST && idx <= tss_pkg::IDX_FREQ_LAST) begin
      rd_byte = s.freq_regs[3'(idx - tss_pkg::IDX_FREQ_FIRST)];
    end else begin
      case (idx)
        tss_pkg::IDX_CP_HI: begin
          rd_byte = s.cp_hi;
        end
        tss_pkg::IDX_CP_LO: begin
          rd_byte = s.cp_lo;
        end
        tss_pkg::IDX_FAST: begin
          rd_byte[tss_pkg::POS_FAST_LOCK] = s.fast_lock_enable;
        end
        tss_pkg::IDX_LO_DIVIDE_SELECT: begin
          rd_byte[1:0] = s.lo_divide_select;
        end
        tss_pkg::IDX_TXLVL: begin
          rd_byte[1:0] = s.tx_output_level;
        end
        tss_pkg::IDX_CAL: begin
          // Start bits are one-shot and read back as zero
          rd_byte[tss_pkg::POS_CAL_BUSY] = cal_busy;
        end
        tss_pkg::IDX_POWER: begin
          rd_byte[3:0] = s.power;
        end
        tss_pkg::IDX_RSSI: begin
          rd_byte = rssi_code_i; // R19
        end
        tss_pkg::IDX_STATUS: begin
          rd_byte[tss_pkg::POS_ST_FREQ_VALID] = s.freq_valid;
          rd_byte[tss_pkg::POS_ST_FAULT] = s.synth_fault;
          rd_byte[tss_pkg::POS_ST_CAL_BUSY] = cal_busy;
          rd_byte[tss_pkg::POS_ST_HW_READY] = hw_ready;
        end
        default: begin
          rd_byte = tss_pkg::RST_BYTE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    // Reset pin crosses in through two flops
    next_s.hw_sync = {s.hw_sync[0], hw_reset_n_i};
    next_s.freq_load = 1'b0;
    next_s.ack = rd_take;
    next_s.dat = rd_take ? {24'h0, rd_byte} : s.dat;
    next_s.synth_prev = s.power[tss_pkg::POS_PWR_SYNTH];

    if (wr_en) begin
      if (idx >= tss_pkg::IDX_FREQ_FIRST
          && idx <= tss_pkg::IDX_FREQ_LAST) begin
        next_s.freq_regs[3'(idx - tss_pkg::IDX_FREQ_FIRST)] = wbyte;
      end
      case (idx)
        tss_pkg::IDX_CP_HI: begin
          next_s.cp_hi = wbyte; // R18
        end
        tss_pkg::IDX_CP_LO: begin
          next_s.cp_lo = wbyte; // R18
        end
        tss_pkg::IDX_FAST: begin
          next_s.fast_lock_enable = wbyte[tss_pkg::POS_FAST_LOCK];
        end
        tss_pkg::IDX_LO_DIVIDE_SELECT: begin
          next_s.lo_divide_select = wbyte[1:0]; // R21
        end
        tss_pkg::IDX_TXLVL: begin
          next_s.tx_output_level = wbyte[1:0]; // R20
        end
        tss_pkg::IDX_POWER: begin
          next_s.power = wbyte[3:0];
        end
        tss_pkg::IDX_SOFT_RST: begin
          next_s.soft_reset_cmd = wbyte[tss_pkg::POS_SOFT_RST]; // R14
        end
        default: begin
        end
      endcase
      // Commit uses the byte being written to the last register
      if (idx == tss_pkg::IDX_FREQ_LAST) begin // R4
        next_s.freq_active = next_s.freq_regs;
        next_s.freq_valid = 1'b1;
        next_s.freq_load = 1'b1;
        next_s.freq_fast = s.fast_lock_enable; // R7
      end
    end

    // Power-down drops the working frequency, stored bytes remain
    if (synth_fall) begin // R11
      next_s.freq_active = tss_pkg::RST_FREQ;
      next_s.freq_valid = 1'b0;
      next_s.freq_load = 1'b0;
    end

    // Fault clears when the buffer goes off; a new fault still wins
    if (!s.power[tss_pkg::POS_PWR_CLKBUF]) begin // R14
      next_s.synth_fault = 1'b0;
    end
    if (synth_fall && s.power[tss_pkg::POS_PWR_CLKBUF]
        && !s.freq_valid) begin // R13
      next_s.synth_fault = 1'b1;
    end

    // Pin reset and soft reset return every register to default
    if (!hw_ready || s.soft_reset_cmd) begin // R14
      next_s.soft_reset_cmd = 1'b0;
      next_s.freq_regs = tss_pkg::RST_FREQ;
      next_s.cp_hi = tss_pkg::RST_BYTE;
      next_s.cp_lo = tss_pkg::RST_BYTE;
      next_s.fast_lock_enable = 1'b0;
      next_s.lo_divide_select = tss_pkg::RST_FIELD2;
      next_s.tx_output_level = tss_pkg::RST_FIELD2;
      next_s.power = tss_pkg::RST_POWER;
      next_s.synth_prev = 1'b0;
      next_s.freq_active = tss_pkg::RST_FREQ;
      next_s.freq_valid = 1'b0;
      next_s.freq_load = 1'b0;
      next_s.freq_fast = 1'b0;
      next_s.synth_fault = 1'b0;
    end
  end

  assign synth_fall = s.synth_prev && !s.power[tss_pkg::POS_PWR_SYNTH];

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s.hw_sync <= 2'h0;
      s.soft_reset_cmd <= 1'b0;
      s.freq_regs <= tss_pkg::RST_FREQ;
      s.cp_hi <= tss_pkg::RST_BYTE;
      s.cp_lo <= tss_pkg::RST_BYTE;
      s.fast_lock_enable <= 1'b0;
      s.lo_divide_select <= tss_pkg::RST_FIELD2;
      s.tx_output_level <= tss_pkg::RST_FIELD2;
      s.power <= tss_pkg::RST_POWER;
      s.synth_prev <= 1'b0;
      s.freq_active <= tss_pkg::RST_FREQ;
      s.freq_valid <= 1'b0;
      s.freq_load <= 1'b0;
      s.freq_fast <= 1'b0;
      s.synth_fault <= 1'b0;
      s.ack <= 1'b0;
      s.dat <= tss_pkg::RST_WORD;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.dat;
  assign power_o = {s.power[tss_pkg::POS_PWR_REF],
    s.power[tss_pkg::POS_PWR_RX],
    s.power[tss_pkg::POS_PWR_CLKBUF],
    s.power[tss_pkg::POS_PWR_SYNTH]};
  assign freq_word_o = s.freq_active;
  assign freq_load_o = s.freq_load; // R4
  assign fast_lock_o = s.freq_fast; // R7
  assign synth_fault_o = s.synth_fault;
  // Code n gives 80 uA times (n + 1)
  assign cp_current_code_o = {s.cp_hi[tss_pkg::POS_CP_HI],
    s.cp_lo[3:0]}; // R18
  assign tx_output_level_o = s.tx_output_level; // R20
  assign lo_divide_select_o = s.lo_divide_select; // R21
  assign analog_offset_cal_start_o = cal_ana_start; // R15
  assign digital_offset_cal_start_o = cal_dig_start; // R17

endmodule

`default_nettype wire

// ===== tss_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tss_top_chk #(
  parameter logic [23:0] CAL_WAIT_CYC = 24'(tss_pkg::CAL_WAIT_CYC)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic hw_reset_n_i,
  input wire tss_pkg::tss_power_t power_o,
  input wire logic [63:0] freq_word_o,
  input wire logic freq_load_o,
  input wire logic fast_lock_o,
  input wire logic synth_fault_o,
  input wire logic [4:0] cp_current_code_o,
  input wire logic [1:0] tx_output_level_o,
  input wire logic [1:0] lo_divide_select_o,
  input wire logic analog_offset_cal_start_o,
  input wire logic digital_offset_cal_start_o
);
  logic [7:0] idx;
  logic wr;
  logic [23:0] since_ana;
  assign idx = wb_adr_i[9:2];
  assign wr = wb_ack_o && wb_we_i;
  // ----------------------------------------------------------------
  // Cycles since the last analog start
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || analog_offset_cal_start_o) begin
      since_ana <= 24'h0;
    end else if (since_ana != 24'hffffff) begin
      since_ana <= since_ana + 24'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  // Pin reset returns registers to default, so changes there are legal
  default disable iff (rst_i || !hw_reset_n_i);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_req_gets_ack: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  a_reset_blocks_wr: assert property (
    disable iff (rst_i) (!hw_reset_n_i) [*4] |-> power_o == 4'h0)
    else $error("power bits set under pin reset");
  a_load_on_commit: assert property (
    freq_load_o |-> $past(wr && idx == 8'h08))
    else $error("frequency load without commit write");
  a_word_on_load: assert property (
    $changed(freq_word_o) |-> freq_load_o || freq_word_o == 64'h0)
    else $error("frequency word changed outside a commit");
  a_fast_on_load: assert property (
    $changed(fast_lock_o) |-> freq_load_o || !fast_lock_o)
    else $error("fast lock changed outside a commit");
  a_down_clears: assert property (
    $fell(power_o.synth_on) |-> ##[0:2] freq_word_o == 64'h0)
    else $error("frequency kept after synth power-down");
  a_ana_cause: assert property (
    analog_offset_cal_start_o |-> $past(wr && idx == 8'h17))
    else $error("analog start without calibration write");
  a_dig_cause: assert property (
    digital_offset_cal_start_o |-> $past(wr && idx == 8'h17) ||
    (since_ana >= CAL_WAIT_CYC - 24'h2 && since_ana <= CAL_WAIT_CYC))
    else $error("digital start at wrong time");
  a_cp_cause: assert property (
    $changed(cp_current_code_o) |->
    $past(wr && (idx == 8'h0a || idx == 8'h0b)) ||
    $past(wr && idx == 8'h3c, 2))
    else $error("charge pump code changed without write");
  // Soft reset clears one cycle after its own write lands
  a_tx_cause: assert property (
    $changed(tx_output_level_o) |-> $past(wr && idx == 8'h13) ||
    $past(wr && idx == 8'h3c, 2))
    else $error("transmit level changed without write");
  a_div_cause: assert property (
    $changed(lo_divide_select_o) |-> $past(wr && idx == 8'h12) ||
    $past(wr && idx == 8'h3c, 2))
    else $error("divider select changed without write");
  c_commit: cover property (freq_load_o);
  c_auto_dig: cover property (digital_offset_cal_start_o && since_ana > 1);
  c_fault: cover property ($rose(synth_fault_o));
endmodule
bind tss_top tss_top_chk #(.CAL_WAIT_CYC(CAL_WAIT_CYC)) tss_top_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
  .hw_reset_n_i(hw_reset_n_i), .power_o(power_o),
  .freq_word_o(freq_word_o), .freq_load_o(freq_load_o),
  .fast_lock_o(fast_lock_o), .synth_fault_o(synth_fault_o),
  .cp_current_code_o(cp_current_code_o),
  .tx_output_level_o(tx_output_level_o),
  .lo_divide_select_o(lo_divide_select_o),
  .analog_offset_cal_start_o(analog_offset_cal_start_o),
  .digital_offset_cal_start_o(digital_offset_cal_start_o));
`default_nettype wire

// ===== tss_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module tss_top_test;
  localparam logic [23:0] W = 24'd20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h0;
  logic rel = 1'b0;
  logic [7:0] rssi = 8'h00;
  logic [31:0] rdat, r;
  logic ack, hw_n, fload, fast, fault, ana, dig;
  logic [7:0] rssi_c;
  tss_pkg::tss_power_t pwr;
  logic [63:0] fword;
  logic [4:0] cp;
  logic [1:0] txl, lod;
  int failures = 0;
  int tests_run = 0;
  int m [256];
  int load_n = 0, ana_n = 0, dig_n = 0, v, f, a0, d0;
  time ana_t, dig_t;
  tss_host_side #(.HOLD_CYC(100)) tss_host_side_inst (.clk_i(clk_i),
    .release_i(rel), .rssi_i(rssi), .hw_reset_n_o(hw_n),
    .rssi_code_o(rssi_c));
  tss_top #(.CAL_WAIT_CYC(W)) tss_top_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .hw_reset_n_i(hw_n), .rssi_code_i(rssi_c), .power_o(pwr),
    .freq_word_o(fword), .freq_load_o(fload), .fast_lock_o(fast),
    .synth_fault_o(fault), .cp_current_code_o(cp),
    .tx_output_level_o(txl), .lo_divide_select_o(lod),
    .analog_offset_cal_start_o(ana), .digital_offset_cal_start_o(dig));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (fload === 1'b1) begin
      load_n++;
    end
    if (ana === 1'b1) begin
      ana_n++;
      ana_t = $time;
    end
    if (dig === 1'b1) begin
      dig_n++;
      dig_t = $time;
    end
  end
  function automatic logic [63:0] fw();
    logic [63:0] w;
    for (int k = 1; k <= 8; k++) begin
      w[8*k-8 +: 8] = 8'(m[k]);
    end
    return w;
  endfunction
  // Values seen at an edge are those from before its updates land
  task automatic bus(input logic w, input logic [7:0] i,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
    if (w) begin
      m[i] = d;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_i);
    failures++;
    report_and_stop();
  end
  initial begin
    v = $urandom(32'h5e9348ac);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b1, 8'h2e, 8'h0f);
    m[8'h2e] = 0;
    bus(1'b0, 8'h2e, 8'h00);
    `CHK(r[3:0], 4'h0)
    rel <= 1'b1;
    repeat (110) @(posedge clk_i);
    bus(1'b0, 8'h3b, 8'h00);
    `CHK(r[3], 1'b1)
    $display("test pin reset done");
    bus(1'b1, 8'h2e, 8'h01);
    bus(1'b1, 8'h2e, 8'h03);
    bus(1'b1, 8'h2e, 8'h0f);
    repeat (50000) @(posedge clk_i);
    bus(1'b0, 8'h2e, 8'h00);
    `CHK(r[3:0], 4'(m[8'h2e]))
    `CHK({pwr.synth_on, pwr.clock_buffer_on, pwr.rx_analog_on,
      pwr.ref_on}, 4'(m[8'h2e]))
    for (int k = 1; k <= 7; k++) begin
      bus(1'b1, 8'(k), 8'($urandom));
    end
    f = $urandom % 2;
    bus(1'b1, 8'h0c, 8'(f));
    `CHK(fword, 64'h0)
    a0 = load_n;
    bus(1'b1, 8'h08, 8'($urandom));
    repeat (3) @(posedge clk_i);
    `CHK(load_n - a0, 1)
    `CHK(fword, fw())
    `CHK(fast, f[0])
    $display("test commit done");
    bus(1'b1, 8'h2e, 8'h03);
    repeat (4) @(posedge clk_i);
    `CHK(fword, 64'h0)
    for (int k = 1; k <= 8; k++) begin
      bus(1'b0, 8'(k), 8'h00);
      `CHK(r[7:0], 8'(m[k]))
    end
    bus(1'b1, 8'h2e, 8'h0f);
    bus(1'b1, 8'h08, 8'(m[8]));
    repeat (3) @(posedge clk_i);
    `CHK(fword, fw())
    bus(1'b1, 8'h2e, 8'h07);
    repeat (3) @(posedge clk_i);
    `CHK(fault, 1'b0)
    bus(1'b1, 8'h2e, 8'h0f);
    bus(1'b1, 8'h2e, 8'h07);
    repeat (3) @(posedge clk_i);
    `CHK(fault, 1'b1)
    bus(1'b1, 8'h2e, 8'h03);
    repeat (3) @(posedge clk_i);
    `CHK(fault, 1'b0)
    $display("test power-down done");
    for (int p = 0; p < 2; p++) begin
      a0 = ana_n;
      d0 = dig_n;
      bus(1'b1, 8'h17, (p == 1) ? 8'h0c : 8'h03);
      repeat (40) @(posedge clk_i);
      `CHK(ana_n - a0, 1)
      `CHK(dig_n - d0, 1)
      `CHK((dig_t - ana_t) / 10, 64'(W))
    end
    a0 = ana_n;
    d0 = dig_n;
    bus(1'b1, 8'h17, 8'h01);
    repeat (5) @(posedge clk_i);
    `CHK(ana_n - a0, 1)
    `CHK(dig_n - d0, 0)
    repeat (W) @(posedge clk_i);
    bus(1'b1, 8'h17, 8'h02);
    repeat (5) @(posedge clk_i);
    `CHK(dig_n - d0, 1)
    $display("test calibration done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h13, 8'(i));
      bus(1'b1, 8'h12, 8'(3 - i));
      repeat (2) @(posedge clk_i);
      `CHK(txl, 2'(i))
      `CHK(lod, 2'(3 - i))
    end
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 0 : (i == 1) ? 31 : $urandom % 32;
      bus(1'b1, 8'h0a, 8'(v >> 4));
      bus(1'b1, 8'h0b, 8'(v & 15));
      repeat (2) @(posedge clk_i);
      `CHK(cp, 5'(v))
      `CHK(80 * (int'(cp) + 1), (i == 1) ? 2560 : 80 * (v + 1))
    end
    rssi <= 8'($urandom);
    repeat (3) @(posedge clk_i);
    bus(1'b0, 8'h3a, 8'h00);
    `CHK(r[7:0], rssi)
    bus(1'b0, 8'h40, 8'h00);
    `CHK(r, 32'h0)
    bus(1'b1, 8'h3c, 8'h01);
    repeat (3) @(posedge clk_i);
    `CHK(txl, 2'h0)
    `CHK(cp, 5'h00)
    bus(1'b0, 8'h08, 8'h00);
    `CHK(r[7:0], 8'h00)
    $display("test fields done");
    report_and_stop();
  end
endmodule
`default_nettype wire
